// ### rtl/fsbp_params.svh
// Purpose: Constants for the flash status and block protection logic.
// Assumes: One 20 MHz system clock; serial link sampled, not clocked.
// Notes:   Opcodes and busy times are local choices of this block.
`ifndef FSBP_PARAMS_SVH
`define FSBP_PARAMS_SVH

// Status register field positions
`define FSBP_SR_SRWD      7
`define FSBP_SR_BP3       6
`define FSBP_SR_TB        5
`define FSBP_SR_WEL       1
`define FSBP_SR_WIP       0
// Flag status register field positions
`define FSBP_FS_READY     7
`define FSBP_FS_ERASE_ERR 5
`define FSBP_FS_PROG_ERR  4
`define FSBP_FS_PROT_ERR  1
`define FSBP_FS_ADDR4     0
// Reset values of the stored status fields
`define FSBP_SRWD_RST     1'b0
`define FSBP_TB_RST       1'b0
`define FSBP_BP_RST       4'h0
// Array geometry
`define FSBP_ADDR_W       26
`define FSBP_SECT_LSB     16
`define FSBP_SECT_W       10
`define FSBP_BP_ALL       4'hb
// Command opcodes
`define FSBP_OP_WRSR      8'h01
`define FSBP_OP_PROG      8'h12
`define FSBP_OP_RDSR      8'h05
`define FSBP_OP_WRDI      8'h04
`define FSBP_OP_WREN      8'h06
`define FSBP_OP_RDFS      8'h70
`define FSBP_OP_CLFS      8'h50
`define FSBP_OP_SE64      8'hdc
`define FSBP_OP_SE4       8'h21
`define FSBP_OP_BULK      8'hc7
// Timing: clock period and busy times in ns, cycles derived
`define FSBP_CLK_NS       50
`define FSBP_T_WRSR_NS    2000
`define FSBP_T_PROG_NS    10000
`define FSBP_T_ERASE_NS   100000
`define FSBP_T_BULK_NS    200000
`define FSBP_CYC(ns)      (((ns) + `FSBP_CLK_NS - 1) / `FSBP_CLK_NS)
`define FSBP_ADDR_BYTES   3'd4

`endif

// ### rtl/fsbp_pkg.sv
// Purpose: Types shared by the status and block protection design.
// Assumes: Constants live in fsbp_params.svh.
// Notes:   Parser states only.
package fsbp_pkg;
  // Frame parser states
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_WDATA,
    ST_PDATA,
    ST_READ,
    ST_SKIP
  } fsbp_state_e;
endpackage

// ### rtl/fsbp_range_check.sv
// Purpose: Decide whether a 64KB sector lies in the protected area.
// Assumes: Purely combinational; inputs from registered state.
// Notes:   Sector index is the upper address bits.
`timescale 1ns/1ps
`include "fsbp_params.svh"
module fsbp_range_check (
  input  wire logic [3:0]              bp_i,      // Block protect code
  input  wire logic                    tb_i,      // 1 anchors at bottom
  input  wire logic [`FSBP_SECT_W-1:0] sector_i,  // Target sector
  output logic                         protect_o  // Sector is protected
);
  logic [`FSBP_SECT_W:0] span;   // Number of protected sectors
  logic [`FSBP_SECT_W:0] sect_x; // Sector widened for compare

  // Size of the protected area from the code
  always_comb begin
    sect_x = {1'b0, sector_i};
    span   = '0;
    if (bp_i >= `FSBP_BP_ALL) begin
      span = 11'h400;
    end else if (bp_i != 4'h0) begin
      span = 11'h001 << (bp_i - 4'h1);
    end
  end

  // Compare against top or bottom anchored range
  always_comb begin
    if (tb_i) begin
      protect_o = sect_x < span;
    end else begin
      protect_o = sect_x >= (11'h400 - span);
    end
  end
endmodule

// ### rtl/fsbp_top.sv
// Purpose: Status register, block protection and serial command front.
// Assumes: Serial pins sampled by clock_i; link clock mode 0.
// Notes:   The array itself lies outside; only gated starts leave here.
`timescale 1ns/1ps
`include "fsbp_params.svh"
module fsbp_top (
  input  wire logic                    clock_i,     // System clock
  input  wire logic                    resetn_i,    // Sync reset, low
  input  wire logic                    sel_n_i,     // Chip select, low
  input  wire logic                    sck_i,       // Serial clock
  input  wire logic                    mosi_i,      // Serial data in
  input  wire logic                    wp_n_i,      // Write protect pin
  output logic                         miso_o,      // Serial data out
  output logic                         miso_oe_o,   // Data out drive
  output logic                         op_start_o,  // Array op pulse
  output logic [1:0]                   op_kind_o,   // 0 prog 1 sect 2 bulk
  output logic [`FSBP_ADDR_W-1:0]      op_addr_o    // Array op address
);
  import fsbp_pkg::*;

  // Synchronisers and edge history
  logic [1:0] sel_sy, sck_sy, mosi_sy, wp_sy;  // First, second stage
  logic       sel_d, sck_d;                    // Third stage for edges
  logic       sck_rise, sck_fall, frame_end;   // Decoded events
  // Byte receiver
  logic [6:0] rx_sr_reg;      // Shift in bits
  logic [2:0] rx_cnt_reg;     // Bits gathered
  logic       byte_vld_reg;   // One-cycle byte pulse
  logic [7:0] byte_reg;       // Received byte
  // Parser
  fsbp_state_e state_reg;                // Frame parser state
  logic [7:0]  opcode_reg;               // Command of this frame
  logic [31:0] addr_reg;                 // Gathered address
  logic [2:0]  addr_cnt_reg;             // Address bytes gathered
  logic [7:0]  wdata_reg;                // Status write data
  logic        have_wdata_reg;           // Status data byte arrived
  logic        have_addr_reg;            // Full address arrived
  // Status and flag state
  logic       srwd_reg;                  // Write disable control
  logic       tb_reg;                    // Top or bottom anchor
  logic [3:0] bp_reg;                    // Block protect code
  logic       wel_reg;                   // Write enable latch
  logic       prot_err_reg;              // Protection error flag
  logic       prog_err_reg;              // Program error flag
  logic       erase_err_reg;             // Erase error flag
  logic [11:0] busy_cnt_reg;             // Busy cycles remaining
  logic [11:0] busy_len_reg;             // Busy length to load
  logic       busy_go_reg;               // Load the busy timer
  logic       busy, busy_done;           // Timer decodes
  logic       fs_ready;                  // Controller ready
  logic       hw_lock;                   // Status frozen by pin
  logic       sect_prot;                 // Target sector protected
  logic [7:0] status_byte, flag_byte;    // Readable images
  // Output shifter
  logic [7:0] tx_sr_reg;                 // Outgoing bits
  logic [2:0] tx_cnt_reg;                // Bits sent of byte

  // Two flip-flops on each pin, a third for edges
  always_ff @(posedge clock_i) begin
    sel_sy  <= {sel_sy[0], sel_n_i};
    sck_sy  <= {sck_sy[0], sck_i};
    mosi_sy <= {mosi_sy[0], mosi_i};
    wp_sy   <= {wp_sy[0], wp_n_i};
    sel_d   <= sel_sy[1];
    sck_d   <= sck_sy[1];
  end

  assign sck_rise  = sck_sy[1] & ~sck_d & ~sel_sy[1];
  assign sck_fall  = ~sck_sy[1] & sck_d & ~sel_sy[1];
  assign frame_end = sel_sy[1] & ~sel_d;

  // Shift in a byte on rising serial clock
  always_ff @(posedge clock_i) begin
    byte_vld_reg <= 1'b0;
    if (!resetn_i || sel_sy[1]) begin
      rx_cnt_reg <= 3'h0;
      rx_sr_reg  <= 7'h00;
    end else if (sck_rise) begin
      rx_sr_reg  <= {rx_sr_reg[5:0], mosi_sy[1]};
      rx_cnt_reg <= rx_cnt_reg + 3'h1;
      if (rx_cnt_reg == 3'h7) begin
        byte_vld_reg <= 1'b1;
        byte_reg     <= {rx_sr_reg, mosi_sy[1]};
      end
    end
  end

  // Frame parser: opcode, address and data bytes
  always_ff @(posedge clock_i) begin
    if (!resetn_i || sel_sy[1]) begin
      state_reg      <= ST_CMD;
      addr_cnt_reg   <= 3'h0;
      have_wdata_reg <= 1'b0;
      have_addr_reg  <= 1'b0;
      // Clear the command so an empty frame cannot repeat it
      opcode_reg     <= 8'h00;
      if (!resetn_i) begin
        addr_reg   <= 32'h0;
        wdata_reg  <= 8'h00;
      end
    end else if (byte_vld_reg) begin
      unique case (state_reg)
        ST_CMD: begin
          opcode_reg <= byte_reg;
          unique case (byte_reg)
            `FSBP_OP_RDSR, `FSBP_OP_RDFS: state_reg <= ST_READ;
            `FSBP_OP_WRSR:                state_reg <= ST_WDATA;
            `FSBP_OP_PROG, `FSBP_OP_SE64,
            `FSBP_OP_SE4:                 state_reg <= ST_ADDR;
            default:                      state_reg <= ST_SKIP;
          endcase
        end
        ST_ADDR: begin
          addr_reg     <= {addr_reg[23:0], byte_reg};
          addr_cnt_reg <= addr_cnt_reg + 3'h1;
          if (addr_cnt_reg == `FSBP_ADDR_BYTES - 3'h1) begin
            have_addr_reg <= 1'b1;
            state_reg     <= (opcode_reg == `FSBP_OP_PROG) ?
                             ST_PDATA : ST_SKIP;
          end
        end
        ST_WDATA: begin
          wdata_reg      <= byte_reg;
          have_wdata_reg <= 1'b1;
          state_reg      <= ST_SKIP;
        end
        ST_PDATA, ST_READ, ST_SKIP: state_reg <= state_reg;
      endcase
    end
  end

  assign hw_lock = srwd_reg & ~wp_sy[1];
  assign fs_ready = ~busy;
  assign status_byte = {srwd_reg, bp_reg[3], tb_reg, bp_reg[2:0],
                        wel_reg, ~fs_ready};
  assign flag_byte = {fs_ready, 1'b0, erase_err_reg, prog_err_reg,
                      2'b00, prot_err_reg, 1'b1};

  // Sector of the target address inside the 26-bit array
  fsbp_range_check u_range (
    .bp_i      (bp_reg),
    .tb_i      (tb_reg),
    .sector_i  (addr_reg[`FSBP_SECT_LSB +: `FSBP_SECT_W]),
    .protect_o (sect_prot)
  );

  // Execute the frame's command when select rises
  always_ff @(posedge clock_i) begin
    busy_go_reg <= 1'b0;
    op_start_o  <= 1'b0;
    if (!resetn_i) begin
      srwd_reg      <= `FSBP_SRWD_RST;
      tb_reg        <= `FSBP_TB_RST;
      bp_reg        <= `FSBP_BP_RST;
      wel_reg       <= 1'b0;
      prot_err_reg  <= 1'b0;
      prog_err_reg  <= 1'b0;
      erase_err_reg <= 1'b0;
      busy_len_reg  <= 12'h0;
      op_kind_o     <= 2'h0;
      op_addr_o     <= '0;
    end else if (busy_done) begin
      wel_reg <= 1'b0;  // Latch drops when a write cycle ends
    end else if (frame_end && !busy) begin
      unique case (opcode_reg)
        `FSBP_OP_WREN: wel_reg <= 1'b1;
        `FSBP_OP_WRDI: wel_reg <= 1'b0;
        `FSBP_OP_CLFS: begin
          prot_err_reg  <= 1'b0;
          prog_err_reg  <= 1'b0;
          erase_err_reg <= 1'b0;
        end
        `FSBP_OP_WRSR: begin
          if (have_wdata_reg && wel_reg && !hw_lock) begin
            srwd_reg     <= wdata_reg[`FSBP_SR_SRWD];
            tb_reg       <= wdata_reg[`FSBP_SR_TB];
            bp_reg       <= {wdata_reg[`FSBP_SR_BP3], wdata_reg[4:2]};
            busy_len_reg <= 12'(`FSBP_CYC(`FSBP_T_WRSR_NS));
            busy_go_reg  <= 1'b1;
          end
        end
        `FSBP_OP_PROG, `FSBP_OP_SE64, `FSBP_OP_SE4: begin
          if (have_addr_reg && wel_reg) begin
            if (sect_prot) begin
              prot_err_reg <= 1'b1;
              wel_reg      <= 1'b0;
              if (opcode_reg == `FSBP_OP_PROG) begin
                prog_err_reg <= 1'b1;
              end else begin
                erase_err_reg <= 1'b1;
              end
            end else begin
              op_start_o   <= 1'b1;
              op_kind_o    <= (opcode_reg == `FSBP_OP_PROG) ? 2'h0 : 2'h1;
              op_addr_o    <= addr_reg[`FSBP_ADDR_W-1:0];
              busy_go_reg  <= 1'b1;
              busy_len_reg <= (opcode_reg == `FSBP_OP_PROG) ?
                              12'(`FSBP_CYC(`FSBP_T_PROG_NS)) :
                              12'(`FSBP_CYC(`FSBP_T_ERASE_NS));
            end
          end
        end
        `FSBP_OP_BULK: begin
          if (wel_reg && bp_reg == 4'h0) begin
            op_start_o   <= 1'b1;
            op_kind_o    <= 2'h2;
            op_addr_o    <= '0;
            busy_go_reg  <= 1'b1;
            busy_len_reg <= 12'(`FSBP_CYC(`FSBP_T_BULK_NS));
          end
        end
        default: wel_reg <= wel_reg;  // Reads and unknown codes
      endcase
    end
  end

  // Busy timer covering write, program and erase cycles
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      busy_cnt_reg <= 12'h0;
    end else if (busy_go_reg) begin
      busy_cnt_reg <= busy_len_reg;
    end else if (busy) begin
      busy_cnt_reg <= busy_cnt_reg - 12'h1;
    end
  end

  assign busy      = (busy_cnt_reg != 12'h0) | busy_go_reg;
  assign busy_done = (busy_cnt_reg == 12'h1) & ~busy_go_reg;

  // Drive status bits out on falling serial clock
  always_ff @(posedge clock_i) begin
    if (!resetn_i || sel_sy[1]) begin
      miso_o     <= 1'b0;
      miso_oe_o  <= 1'b0;
      tx_cnt_reg <= 3'h0;
      tx_sr_reg  <= 8'h00;
    end else if (sck_fall && state_reg == ST_READ) begin
      miso_oe_o  <= 1'b1;
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == 3'h0) begin
        // Fresh image each byte so polling sees live busy
        tx_sr_reg <= (opcode_reg == `FSBP_OP_RDFS) ?
                     {flag_byte[6:0], 1'b0} :
                     {status_byte[6:0], 1'b0};
        miso_o    <= (opcode_reg == `FSBP_OP_RDFS) ?
                     flag_byte[7] : status_byte[7];
      end else begin
        miso_o    <= tx_sr_reg[7];
        tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
      end
    end
  end
endmodule

// ### tb/fsbp_asserts.sv
// Purpose: Port checks for the status and block protection front.
// Assumes: One clock domain; bound to fsbp_top.
// Notes:   Start spacing uses the shortest array op busy time, 200 cycles.
`timescale 1ns/1ps
`include "fsbp_params.svh"
module fsbp_checker (
  input wire logic                    clock_i,
  input wire logic                    resetn_i,
  input wire logic                    sel_n_i,
  input wire logic                    sck_i,
  input wire logic                    mosi_i,
  input wire logic                    wp_n_i,
  input wire logic                    miso_o,
  input wire logic                    miso_oe_o,
  input wire logic                    op_start_o,
  input wire logic [1:0]              op_kind_o,
  input wire logic [`FSBP_ADDR_W-1:0] op_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic [8:0] gap_reg; // Cycles since last array start
  // Saturating gap counter
  always_ff @(posedge clock_i) begin
    if (!resetn_i) gap_reg <= 9'h1ff;
    else if (op_start_o) gap_reg <= 9'h000;
    else if (gap_reg != 9'h1ff) gap_reg <= gap_reg + 9'h001;
  end
  property p_oe_rise; $rose(miso_oe_o) |-> !sel_n_i; endproperty
  property p_oe_hold; miso_oe_o && !sel_n_i |=> miso_oe_o; endproperty
  property p_oe_drop; $rose(sel_n_i) |-> ##[1:6] !miso_oe_o; endproperty
  property p_pulse; op_start_o |=> !op_start_o [*3]; endproperty
  property p_desel; op_start_o |-> sel_n_i && $past(sel_n_i, 2); endproperty
  property p_gap; op_start_o |-> gap_reg >= 9'd199; endproperty
  property p_bulk; op_start_o && op_kind_o == 2'd2 |-> op_addr_o == '0;
  endproperty
  property p_kind; op_start_o |-> op_kind_o != 2'd3; endproperty
  property p_reset;
    $rose(resetn_i) |-> !miso_oe_o && !op_start_o && op_kind_o == 2'd0;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("read drive began while deselected");
  a_oe_hold: assert property (p_oe_hold)
    else $error("read drive dropped inside a frame");
  a_oe_drop: assert property (p_oe_drop)
    else $error("read drive held after deselect");
  a_pulse: assert property (p_pulse)
    else $error("array start longer than one cycle");
  a_desel: assert property (p_desel)
    else $error("array start before frame end");
  a_gap: assert property (p_gap)
    else $error("array start during busy time");
  a_bulk: assert property (p_bulk)
    else $error("bulk erase with nonzero address");
  a_kind: assert property (p_kind)
    else $error("undefined array operation kind");
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  c_prog: cover property (op_start_o && op_kind_o == 2'd0);
  c_bulk: cover property (op_start_o && op_kind_o == 2'd2);
  c_read: cover property ($rose(miso_oe_o));
endmodule
bind fsbp_top fsbp_checker fsbp_checker_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .sel_n_i(sel_n_i),
  .sck_i(sck_i), .mosi_i(mosi_i), .wp_n_i(wp_n_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .op_start_o(op_start_o),
  .op_kind_o(op_kind_o), .op_addr_o(op_addr_o));

// ### tb/fsbp_host.sv
// Purpose: Serial host that frames commands for the flash front.
// Assumes: Mode 0 link, 400 ns link period, idle low outside frames.
// Notes:   Reads sample just before each falling link edge.
`timescale 1ns/1ps
module fsbp_host (
  input  wire logic clock_i,
  input  wire logic miso_i,
  output logic      sel_n_o,
  output logic      sck_o,
  output logic      mosi_o
);
  logic [7:0] rx_reg; // Last eight bits returned
  initial begin
    sel_n_o = 1'b1;
    sck_o   = 1'b0;
    mosi_o  = 1'b0;
    rx_reg  = 8'h00;
  end
  // Wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One frame of n bytes from the top of tx, MSB first
  task automatic frame(input logic [47:0] tx, input int n);
    sel_n_o <= 1'b0;
    tick(4);
    for (int k = 0; k < n * 8; k++) begin
      sck_o  <= 1'b0;
      mosi_o <= tx[47-k];
      tick(4);
      sck_o <= 1'b1;
      tick(4);
      rx_reg <= {rx_reg[6:0], miso_i};
    end
    sck_o <= 1'b0;
    tick(4);
    sel_n_o <= 1'b1;
    mosi_o  <= ~mosi_o; // Released line must not keep its value
    tick(8);
  endtask
endmodule

// ### tb/testbench.sv
// Purpose: Command level tests of status and block protection.
// Assumes: Host model frames every command.
// Notes:   Busy waits follow the fixed busy times.
`timescale 1ns/1ps
`include "fsbp_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", nm, e, g); \
  end end
module testbench;
  logic                    clock_i  = 1'b0;
  logic                    resetn_i = 1'b0;
  logic                    wp_n_i   = 1'b1;
  logic                    sel_n, sck, mosi, miso, miso_oe, op_start;
  logic [1:0]              op_kind, kind_seen;
  logic [`FSBP_ADDR_W-1:0] op_addr, addr_seen;
  int                      miscompares = 0;
  int                      num_checks  = 0;
  int                      starts      = 0;
  logic [7:0] sr[10]  = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h40, 8'h40,
                          8'h68, 8'h68, 8'h4c, 8'h7c};
  logic [9:0] sec[10] = '{10'd1023, 10'd1022, 10'd0, 10'd1, 10'd896,
                          10'd895, 10'd511, 10'd512, 10'd0, 10'd1023};
  logic       go[10]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
                          1'b0, 1'b0};
  always #25 clock_i = ~clock_i;
  fsbp_top fsbp_top_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .sel_n_i(sel_n), .sck_i(sck), .mosi_i(mosi), .wp_n_i(wp_n_i),
    .miso_o(miso), .miso_oe_o(miso_oe), .op_start_o(op_start),
    .op_kind_o(op_kind), .op_addr_o(op_addr));
  fsbp_host fsbp_host_i (.clock_i(clock_i), .miso_i(miso),
    .sel_n_o(sel_n), .sck_o(sck), .mosi_o(mosi));
  // Record each array start with its kind and address
  always @(posedge clock_i) begin
    if (op_start === 1'b1) begin
      starts    <= starts + 1;
      kind_seen <= op_kind;
      addr_seen <= op_addr;
    end
  end
  task automatic cmd(input logic [7:0] opc);
    fsbp_host_i.frame({opc, 40'h0}, 1);
  endtask
  task automatic rd(input logic [7:0] opc, input logic [7:0] e);
    fsbp_host_i.frame({opc, 40'h0}, 2);
    `CHK("register", e, fsbp_host_i.rx_reg)
    `CHK("drive", 1'b0, miso_oe)
  endtask
  task automatic wrsr(input logic [7:0] v, input logic en);
    if (en) cmd(`FSBP_OP_WREN);
    fsbp_host_i.frame({`FSBP_OP_WRSR, v, 32'h0}, 2);
    fsbp_host_i.tick(45);
  endtask
  // Enabled array command; checks whether it started and how
  task automatic op(input logic [47:0] tx, input int n, input logic e,
                    input logic [1:0] k, input logic [25:0] a);
    int s0;
    cmd(`FSBP_OP_WREN);
    s0 = starts;
    fsbp_host_i.frame(tx, n);
    `CHK("start", e, starts != s0)
    if (e) begin
      `CHK("kind", k, kind_seen)
      `CHK("address", a, addr_seen)
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    fsbp_host_i.tick(8);
    rd(`FSBP_OP_RDSR, 8'h00);
    wrsr(8'ha4, 1'b0);
    rd(`FSBP_OP_RDSR, 8'h00);
    cmd(`FSBP_OP_WREN);
    rd(`FSBP_OP_RDSR, 8'h02);
    wrsr(8'ha4, 1'b1);
    rd(`FSBP_OP_RDSR, 8'ha4);
    wp_n_i <= 1'b0;
    wrsr(8'h00, 1'b1);
    cmd(`FSBP_OP_WRDI);
    rd(`FSBP_OP_RDSR, 8'ha4);
    wp_n_i <= 1'b1;
    wrsr(8'h00, 1'b1);
    rd(`FSBP_OP_RDSR, 8'h00);
    for (int i = 0; i < 10; i++) begin
      wrsr(sr[i], 1'b1);
      op({`FSBP_OP_PROG, 6'h0, sec[i], 24'ha5}, 6, go[i], 2'd0,
         {sec[i], 16'h0});
      fsbp_host_i.tick(210);
    end
    rd(`FSBP_OP_RDFS, 8'h93);
    cmd(`FSBP_OP_CLFS);
    rd(`FSBP_OP_RDFS, 8'h81);
    op({`FSBP_OP_BULK, 40'h0}, 1, 1'b0, 2'd2, 26'h0);
    wrsr(8'h00, 1'b1);
    op({`FSBP_OP_SE64, 6'h0, 10'd3, 24'h0}, 5, 1'b1, 2'd1,
       {10'd3, 16'h0});
    rd(`FSBP_OP_RDSR, 8'h03);
    fsbp_host_i.tick(2010);
    op({`FSBP_OP_BULK, 40'h0}, 1, 1'b1, 2'd2, 26'h0);
    rd(`FSBP_OP_RDFS, 8'h01);
    rd(`FSBP_OP_RDSR, 8'h03);
    fsbp_host_i.tick(4010);
    rd(`FSBP_OP_RDSR, 8'h00);
    // Subsector erase: protected top sector, then a free one
    wrsr(8'h04, 1'b1);
    op({`FSBP_OP_SE4, 6'h0, 10'd1023, 24'h0}, 5, 1'b0, 2'd1,
       {10'd1023, 16'h0});
    rd(`FSBP_OP_RDFS, 8'ha3);
    op({`FSBP_OP_SE4, 6'h0, 10'd1022, 24'h340000}, 5, 1'b1, 2'd1,
       {10'd1022, 16'h3400});
    test_done();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clock_i);
    miscompares++;
    test_done();
  end
endmodule
